// *** hdl/cam_sp_pkg.sv ***
// Package: register offsets, reset values, field positions and decoded control struct
package cam_sp_pkg;

  // ==========================================================
  // Register offsets (serial bus subaddresses)
  localparam logic [7:0] ADDR_BAND      = 8'h2D;
  localparam logic [7:0] ADDR_VOFF      = 8'h2E;
  localparam logic [7:0] ADDR_VREF      = 8'h2F;
  localparam logic [7:0] ADDR_MEDIAN    = 8'h4C;
  localparam logic [7:0] ADDR_CONV      = 8'h4D;
  localparam logic [7:0] ADDR_SPA       = 8'h60;
  localparam logic [7:0] ADDR_SPB       = 8'h61;
  localparam logic [7:0] ADDR_SPC       = 8'h65;
  localparam logic [7:0] ADDR_WB        = 8'h66;
  localparam logic [7:0] ADDR_MATRIX    = 8'h67;
  localparam logic [7:0] ADDR_EXPREF    = 8'h68;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BAND       = 8'h03;
  localparam logic [7:0] RST_VOFF       = 8'h80;
  localparam logic [7:0] RST_VREF       = 8'h19;
  localparam logic [7:0] RST_MEDIAN     = 8'h00;
  localparam logic [7:0] RST_CONV       = 8'h10;
  localparam logic [7:0] RST_SPA        = 8'h20;
  localparam logic [7:0] RST_SPB        = 8'h80;
  localparam logic [7:0] RST_SPC        = 8'h02;
  localparam logic [7:0] RST_WB         = 8'h55;
  localparam logic [7:0] RST_MATRIX     = 8'h55;
  localparam logic [7:0] RST_EXPREF     = 8'hAC;

  // ==========================================================
  // Writable-bit masks; reserved bits hold their reset value
  localparam logic [7:0] WM_BAND        = 8'h16;
  localparam logic [7:0] WM_VOFF        = 8'hFF;
  localparam logic [7:0] WM_VREF        = 8'hFF;
  localparam logic [7:0] WM_MEDIAN      = 8'h80;
  localparam logic [7:0] WM_CONV        = 8'h0C;
  localparam logic [7:0] WM_SPA         = 8'hFF;
  localparam logic [7:0] WM_SPB         = 8'h9F;
  localparam logic [7:0] WM_SPC         = 8'h07;
  localparam logic [7:0] WM_WB          = 8'hFF;
  localparam logic [7:0] WM_MATRIX      = 8'hDC;
  localparam logic [7:0] WM_EXPREF      = 8'hE0;

  // ==========================================================
  // Field positions
  localparam int BIT_BLACK_EXP   = 4;
  localparam int BIT_BAND_FILT   = 2;
  localparam int BIT_REV_FRAME   = 1;
  localparam int BIT_VOFF_DIR    = 7;
  localparam int BIT_AWB_X15     = 7;
  localparam int POS_UV_DLY      = 2;
  localparam int BIT_G_SWITCH    = 5;
  localparam int BIT_Y_SWITCH    = 4;
  localparam int POS_RED_GAIN    = 2;
  localparam int POS_BLUE_GAIN   = 0;
  localparam int BIT_Y_LOOP      = 7;
  localparam int BIT_BRT_HALF    = 2;
  localparam int POS_BRT_REF     = 0;
  localparam int BIT_ADC_X15     = 2;
  localparam int POS_ADC_REF     = 0;
  localparam int POS_LUM_LIM     = 4;
  localparam int POS_UV_LIM      = 0;
  localparam int POS_UV_COEF     = 6;
  localparam int BIT_UV_AVG      = 4;
  localparam int POS_Y_DLY       = 2;
  localparam int POS_EXP_REF     = 5;

  // ==========================================================
  // Decoded controls delivered to the image pipeline
  typedef struct packed {
    logic       band_filter;
    logic       reverse_frame;
    logic       black_expand;
    logic       voff_subtract;
    logic [6:0] voff_magnitude;
    logic       voff_enable;
    logic       voff_on_red;
    logic       awb_step_x15;
    logic [2:0] uv_delay_pp;
    logic [1:0] red_gain_code;
    logic [1:0] blue_gain_code;
    logic       green_switch;
    logic       luma_switch;
    logic       loop_uses_y;
    logic [4:0] brt_ref_ire;
    logic       brt_half;
    logic       adc_range_x15;
    logic [1:0] adc_ref_sel;
    logic [3:0] lum_limits;
    logic       lum_limits_en;
    logic [3:0] uv_limits;
    logic       uv_limits_en;
    logic [1:0] uv_coef_sel;
    logic       uv_avg3;
    logic [1:0] y_delay_pp;
    logic [2:0] exp_ref_level;
  } pipe_ctrl_t;

endpackage : cam_sp_pkg

// *** hdl/camera_signal_process_regs.sv ***
// Control register bank for the signal-process section of the camera sensor
//
// Functional notes
// - Band filter bit selects banding-safe exposure
// - Reverse division bit swaps dropped and output frames
// - Black expand bit enables black expansion
// - Offset top bit: add or subtract magnitude
// - Manual offset mode: stored bus value used
// - Offset applies only with manual brightness off
// - Median top bit scales white balance 1.5x
// - UV delay codes: 0, 0, 2, 4 periods
// - Preamp gain codes 1x to 1.6x
// - Even/odd green switching instead of averaging
// - Brightness reference 0, 6, 10, 20 IRE
// - Half-range bit halves brightness range, step
// - Luminance limits need their enable bit
// - UV limits need smart threshold enable
// - UV coefficient code selects matrix scale
// - UV averaging bit selects three-point average
// - Y delay 0 to 3 pixel periods
// - Exposure reference 000 lowest, 111 highest
// - Manual offset bit selects host offset values
`timescale 1ns/10ps

module camera_signal_process_regs (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_wr_en,
  input  wire logic [7:0]             i_addr,
  input  wire logic [7:0]             i_wr_data,
  output logic      [7:0]             o_rd_data,
  input  wire logic                   i_manual_offset,
  input  wire logic                   i_manual_brightness,
  input  wire logic                   i_lum_limit_en,
  input  wire logic                   i_smart_thresh_en,
  input  wire logic                   i_raw_rgb_out,
  input  wire logic                   i_voff_upd,
  input  wire logic [7:0]             i_voff_upd_val,
  output cam_sp_pkg::pipe_ctrl_t      o_ctrl
);

  // ==========================================================
  // Mode inputs are static straps from other register banks; synchronised anyway
  logic [4:0] mode_s1_r;
  logic [4:0] mode_s2_r;
  wire  [4:0] mode_raw = {i_manual_offset, i_manual_brightness, i_lum_limit_en, i_smart_thresh_en, i_raw_rgb_out};
  wire        man_off  = mode_s2_r[4];
  wire        man_brt  = mode_s2_r[3];
  wire        lum_en   = mode_s2_r[2];
  wire        smart_en = mode_s2_r[1];
  wire        raw_rgb  = mode_s2_r[0];

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_s1_r <= 5'h00;
      mode_s2_r <= 5'h00;
    end else begin
      mode_s1_r <= mode_raw;
      mode_s2_r <= mode_s1_r;
    end
  end

  // ==========================================================
  // Register storage
  localparam int NREG = 11;
  localparam logic [NREG*8-1:0] ADDRS = {cam_sp_pkg::ADDR_EXPREF, cam_sp_pkg::ADDR_MATRIX, cam_sp_pkg::ADDR_WB,
    cam_sp_pkg::ADDR_SPC, cam_sp_pkg::ADDR_SPB, cam_sp_pkg::ADDR_SPA, cam_sp_pkg::ADDR_CONV,
    cam_sp_pkg::ADDR_MEDIAN, cam_sp_pkg::ADDR_VREF, cam_sp_pkg::ADDR_VOFF, cam_sp_pkg::ADDR_BAND};
  localparam logic [NREG*8-1:0] RSTS = {cam_sp_pkg::RST_EXPREF, cam_sp_pkg::RST_MATRIX, cam_sp_pkg::RST_WB,
    cam_sp_pkg::RST_SPC, cam_sp_pkg::RST_SPB, cam_sp_pkg::RST_SPA, cam_sp_pkg::RST_CONV,
    cam_sp_pkg::RST_MEDIAN, cam_sp_pkg::RST_VREF, cam_sp_pkg::RST_VOFF, cam_sp_pkg::RST_BAND};
  localparam logic [NREG*8-1:0] WMS = {cam_sp_pkg::WM_EXPREF, cam_sp_pkg::WM_MATRIX, cam_sp_pkg::WM_WB,
    cam_sp_pkg::WM_SPC, cam_sp_pkg::WM_SPB, cam_sp_pkg::WM_SPA, cam_sp_pkg::WM_CONV,
    cam_sp_pkg::WM_MEDIAN, cam_sp_pkg::WM_VREF, cam_sp_pkg::WM_VOFF, cam_sp_pkg::WM_BAND};
  localparam int IDX_VOFF = 1;

  logic [7:0]      reg_r [NREG];
  logic [NREG-1:0] hit;
  logic [7:0]      rd_nxt;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      wire [7:0] wmask = WMS[g*8 +: 8];
      wire [7:0] bus_nxt = (reg_r[g] & ~wmask) | (i_wr_data & wmask);
      wire       bus_wr  = i_wr_en && hit[g] && ((g != IDX_VOFF) || man_off);
      wire       int_wr  = (g == IDX_VOFF) && !man_off && i_voff_upd;
      assign hit[g] = (i_addr == ADDRS[g*8 +: 8]);
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          reg_r[g] <= RSTS[g*8 +: 8];
        end else if (int_wr) begin
          reg_r[g] <= i_voff_upd_val;
        end else if (bus_wr) begin
          reg_r[g] <= bus_nxt;
        end
      end
    end
  endgenerate

  // Unmapped subaddresses read as zero
  always_comb begin
    rd_nxt = 8'h00;
    for (int k = 0; k < NREG; k++) begin
      if (hit[k]) begin
        rd_nxt = reg_r[k];
      end
    end
  end

  // ==========================================================
  // Decode into pipeline controls
  wire [7:0] band = reg_r[0];
  wire [7:0] voff = reg_r[1];
  wire [7:0] median_filter_control = reg_r[3];
  wire [7:0] conv = reg_r[4];
  wire [7:0] spa  = reg_r[5];
  wire [7:0] spb  = reg_r[6];
  wire [7:0] spc  = reg_r[7];
  wire [7:0] wb   = reg_r[8];
  wire [7:0] mtx  = reg_r[9];
  wire [7:0] expr = reg_r[10];

  wire [1:0] uv_code  = conv[cam_sp_pkg::POS_UV_DLY +: 2];
  wire [2:0] uv_dly   = (uv_code == 2'h2) ? 3'h2 : (uv_code == 2'h3) ? 3'h4 : 3'h0;
  wire [1:0] ref_code = spb[cam_sp_pkg::POS_BRT_REF +: 2];
  wire [4:0] ref_ire  = (ref_code == 2'h0) ? 5'h00 : (ref_code == 2'h1) ? 5'h06 :
                        (ref_code == 2'h2) ? 5'h0A : 5'h14;

  cam_sp_pkg::pipe_ctrl_t ctrl_nxt;
  always_comb begin
    ctrl_nxt                = '0;
    ctrl_nxt.band_filter    = band[cam_sp_pkg::BIT_BAND_FILT];
    ctrl_nxt.reverse_frame  = band[cam_sp_pkg::BIT_REV_FRAME];
    ctrl_nxt.black_expand   = band[cam_sp_pkg::BIT_BLACK_EXP];
    ctrl_nxt.voff_subtract  = voff[cam_sp_pkg::BIT_VOFF_DIR];
    ctrl_nxt.voff_magnitude = voff[6:0];
    ctrl_nxt.voff_enable    = !man_brt;
    ctrl_nxt.voff_on_red    = raw_rgb;
    ctrl_nxt.awb_step_x15   = median_filter_control[cam_sp_pkg::BIT_AWB_X15];
    ctrl_nxt.uv_delay_pp    = uv_dly;
    ctrl_nxt.red_gain_code  = spa[cam_sp_pkg::POS_RED_GAIN +: 2];
    ctrl_nxt.blue_gain_code = spa[cam_sp_pkg::POS_BLUE_GAIN +: 2];
    ctrl_nxt.green_switch   = spa[cam_sp_pkg::BIT_G_SWITCH];
    ctrl_nxt.luma_switch    = spa[cam_sp_pkg::BIT_Y_SWITCH];
    ctrl_nxt.loop_uses_y    = spb[cam_sp_pkg::BIT_Y_LOOP];
    ctrl_nxt.brt_ref_ire    = ref_ire;
    ctrl_nxt.brt_half       = spb[cam_sp_pkg::BIT_BRT_HALF];
    ctrl_nxt.adc_range_x15  = spc[cam_sp_pkg::BIT_ADC_X15];
    ctrl_nxt.adc_ref_sel    = spc[cam_sp_pkg::POS_ADC_REF +: 2];
    ctrl_nxt.lum_limits     = wb[cam_sp_pkg::POS_LUM_LIM +: 4];
    ctrl_nxt.lum_limits_en  = lum_en;
    ctrl_nxt.uv_limits      = wb[cam_sp_pkg::POS_UV_LIM +: 4];
    ctrl_nxt.uv_limits_en   = smart_en;
    ctrl_nxt.uv_coef_sel    = mtx[cam_sp_pkg::POS_UV_COEF +: 2];
    ctrl_nxt.uv_avg3        = mtx[cam_sp_pkg::BIT_UV_AVG];
    ctrl_nxt.y_delay_pp     = mtx[cam_sp_pkg::POS_Y_DLY +: 2];
    ctrl_nxt.exp_ref_level  = expr[cam_sp_pkg::POS_EXP_REF +: 3];
  end

  // ==========================================================
  // Registered outputs; reset value of ctrl is zero until the first edge after release
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
      o_ctrl    <= '0;
    end else begin
      o_rd_data <= rd_nxt;
      o_ctrl    <= ctrl_nxt;
    end
  end

endmodule : camera_signal_process_regs

// *** sim/cam_sp_regs_asserts.sv ***
// Checker: port-level properties of the signal-process register bank
`timescale 1ns/10ps
module cam_sp_regs_asserts (
  input wire logic                   i_sys_clk,
  input wire logic                   i_reset_n,
  input wire logic                   i_wr_en,
  input wire logic [7:0]             i_addr,
  input wire logic [7:0]             i_wr_data,
  input wire logic [7:0]             o_rd_data,
  input wire logic                   i_manual_offset,
  input wire logic                   i_manual_brightness,
  input wire logic                   i_lum_limit_en,
  input wire logic                   i_smart_thresh_en,
  input wire logic                   i_raw_rgb_out,
  input wire logic                   i_voff_upd,
  input wire logic [7:0]             i_voff_upd_val,
  input wire cam_sp_pkg::pipe_ctrl_t o_ctrl
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================
  // Offset register ownership
  wire       wr_voff = i_wr_en && i_addr == 8'h2E;
  wire [7:0] voff    = {o_ctrl.voff_subtract, o_ctrl.voff_magnitude};
  // Mode needs four quiet samples: one more than the two sync flops plus the write edge itself
  property p_voff_man;
    i_manual_offset[*4] ##0 (wr_voff && !i_voff_upd) |-> ##2 voff == $past(i_wr_data, 2);
  endproperty
  a_voff_man: assert property (p_voff_man) else $error("offset write lost in manual mode");
  property p_voff_auto;
    (!i_manual_offset && !i_voff_upd)[*4] ##0 wr_voff ##1 !i_voff_upd |=> $stable(voff);
  endproperty
  a_voff_auto: assert property (p_voff_auto) else $error("offset write taken in auto mode");
  property p_voff_upd;
    (!i_manual_offset)[*4] ##0 i_voff_upd |-> ##2 voff == $past(i_voff_upd_val, 2);
  endproperty
  a_voff_upd: assert property (p_voff_upd) else $error("internal offset update lost");
  // ==========================================
  // Decoded fields after a write, and mode inputs reflected once stable
  property p_band;
    (i_wr_en && i_addr == 8'h2D) |-> ##2 {o_ctrl.band_filter, o_ctrl.reverse_frame, o_ctrl.black_expand}
      == {$past(i_wr_data[2], 2), $past(i_wr_data[1], 2), $past(i_wr_data[4], 2)};
  endproperty
  a_band: assert property (p_band) else $error("band control decode wrong");
  property p_uvdly;
    (i_wr_en && i_addr == 8'h4D) |-> ##2 o_ctrl.uv_delay_pp
      == ($past(i_wr_data[3], 2) ? ($past(i_wr_data[2], 2) ? 3'h4 : 3'h2) : 3'h0);
  endproperty
  a_uvdly: assert property (p_uvdly) else $error("uv delay decode wrong");
  property p_brt;
    (i_wr_en && i_addr == 8'h61) |-> ##2 o_ctrl.brt_half == $past(i_wr_data[2], 2) && o_ctrl.brt_ref_ire
      == ($past(i_wr_data[1], 2) ? ($past(i_wr_data[0], 2) ? 5'h14 : 5'h0A)
                                 : ($past(i_wr_data[0], 2) ? 5'h06 : 5'h00));
  endproperty
  a_brt: assert property (p_brt) else $error("brightness reference decode wrong");
  property p_modes;
    $stable({i_manual_brightness, i_raw_rgb_out, i_lum_limit_en, i_smart_thresh_en})[*4] |->
      {o_ctrl.voff_enable, o_ctrl.voff_on_red, o_ctrl.lum_limits_en, o_ctrl.uv_limits_en}
      == {!i_manual_brightness, i_raw_rgb_out, i_lum_limit_en, i_smart_thresh_en};
  endproperty
  a_modes: assert property (p_modes) else $error("mode input not reflected");
  // ==========================================
  // Reads and reset
  property p_unmapped;
    i_addr == 8'h30 |=> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dflt;
    $rose(i_reset_n) |=> o_ctrl.reverse_frame && !o_ctrl.band_filter && o_ctrl.loop_uses_y
      && o_ctrl.exp_ref_level == 3'h5 && o_ctrl.uv_coef_sel == 2'h1;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults missing after reset");
endmodule : cam_sp_regs_asserts

// *** sim/cam_host.sv ***
// Host model: drives writes and reads on the register port
`timescale 1ns/10ps
module cam_host (
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_rd_data,
  output logic            o_wr_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wr_data
);
  initial begin
    o_wr_en = 1'h0;
    o_addr = 8'h00;
    o_wr_data = 8'h00;
  end
  // Callers keep the loop bit low in RGB and the converter reference at its recommended value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_wr_en = 1'h1;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_sys_clk);
    o_wr_en = 1'h0;
    o_wr_data = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_addr = a;
    @(negedge i_sys_clk);
    d = i_rd_data;
  endtask : rd
endmodule : cam_host

// *** sim/tb_camera_signal_process_regs.sv ***
// Testbench: host model driving the register bank, shadow-model checks
`timescale 1ns/10ps
module tb_camera_signal_process_regs;
  localparam logic [7:0] AD  [11] = '{8'h2D, 8'h2E, 8'h2F, 8'h4C, 8'h4D, 8'h60, 8'h61, 8'h65, 8'h66, 8'h67, 8'h68};
  localparam logic [7:0] RV  [11] = '{8'h03, 8'h80, 8'h19, 8'h00, 8'h10, 8'h20, 8'h80, 8'h02, 8'h55, 8'h55, 8'hAC};
  localparam logic [7:0] WM  [11] = '{8'h16, 8'hFF, 8'hFF, 8'h80, 8'h0C, 8'hFF, 8'h9F, 8'h07, 8'hFF, 8'hDC, 8'hE0};
  localparam logic [7:0] PAT [4]  = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
  localparam logic [4:0] IRE [4]  = '{5'h00, 5'h06, 5'h0A, 5'h14};
  logic                   clk, rst_n, wr_en, man_off, man_brt, lum_en, sm_en, raw, upd;
  logic [7:0]             addr, wdata, rdata, upd_val, g;
  logic [7:0]             sh [11];
  cam_sp_pkg::pipe_ctrl_t ctrl;
  int                     n_fail = 0, checks_done = 0, cyc = 0;
  camera_signal_process_regs camera_signal_process_regs_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_wr_en(wr_en),
    .i_addr(addr), .i_wr_data(wdata), .o_rd_data(rdata), .i_manual_offset(man_off), .i_manual_brightness(man_brt),
    .i_lum_limit_en(lum_en), .i_smart_thresh_en(sm_en), .i_raw_rgb_out(raw), .i_voff_upd(upd),
    .i_voff_upd_val(upd_val), .o_ctrl(ctrl));
  cam_host cam_host_i (.i_sys_clk(clk), .i_rd_data(rdata), .o_wr_en(wr_en), .o_addr(addr), .o_wr_data(wdata));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // Expected decode from the shadow registers
  function automatic cam_sp_pkg::pipe_ctrl_t exp_ctrl();
    logic [2:0] uvd;
    uvd = sh[4][3] ? (sh[4][2] ? 3'h4 : 3'h2) : 3'h0;
    return {sh[0][2], sh[0][1], sh[0][4], sh[1],
      !man_brt, raw, sh[3][7], uvd,
      sh[5][3:0], sh[5][5:4],
      sh[6][7], IRE[sh[6][1:0]], sh[6][2], sh[7][2:0],
      sh[8][7:4], lum_en, sh[8][3:0], sm_en,
      sh[9][7:6], sh[9][4:2], sh[10][7:5]};
  endfunction : exp_ctrl
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic put(input int i, input logic [7:0] d);
    cam_host_i.wr(AD[i], d);
    if (i != 1 || man_off) sh[i] = (sh[i] & ~WM[i]) | (d & WM[i]);
  endtask : put
  task automatic chk_all();
    repeat (4) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      cam_host_i.rd(AD[i], g);
      cmp(g, sh[i]);
    end
    checks_done++;
    if (ctrl !== exp_ctrl()) begin
      n_fail++;
      $display("[FAIL] %0t ctrl got %h exp %h", $time, ctrl, exp_ctrl());
    end
  endtask : chk_all
  task automatic do_reset();
    rst_n = 1'h0;
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    sh = RV;
  endtask : do_reset
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, man_off, man_brt, lum_en, sm_en, raw, upd, upd_val} = '0;
    do_reset();
    chk_all();
    man_off = 1'h1;
    foreach (PAT[p]) begin
      {man_brt, raw, lum_en, sm_en} = PAT[p][3:0];
      for (int i = 0; i < 11; i++) begin
        put(i, (i == 6 && raw) ? PAT[p] & 8'h7F : (i == 7) ? (PAT[p] & 8'hFC) | 8'h02 : PAT[p]);
      end
      chk_all();
    end
    man_off = 1'h0;
    repeat (3) @(negedge clk);
    put(1, 8'h12);
    chk_all();
    upd_val = 8'hC3;
    upd = 1'h1;
    @(negedge clk);
    upd = 1'h0;
    upd_val = 8'h3C;
    sh[1] = 8'hC3;
    chk_all();
    cam_host_i.wr(8'h30, 8'hFF);
    cam_host_i.rd(8'h30, g);
    cmp(g, 8'h00);
    chk_all();
    do_reset();
    chk_all();
    print_verdict();
  end
endmodule : tb_camera_signal_process_regs

bind camera_signal_process_regs cam_sp_regs_asserts cam_sp_regs_asserts_i (.i_sys_clk(i_sys_clk),
  .i_reset_n(i_reset_n), .i_wr_en(i_wr_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
  .i_manual_offset(i_manual_offset), .i_manual_brightness(i_manual_brightness), .i_lum_limit_en(i_lum_limit_en),
  .i_smart_thresh_en(i_smart_thresh_en), .i_raw_rgb_out(i_raw_rgb_out), .i_voff_upd(i_voff_upd),
  .i_voff_upd_val(i_voff_upd_val), .o_ctrl(o_ctrl));
